/* rtl/chs_codec_end.sv */
/*
  Codec end: frames the sample stream in 160-sample segments, detects homing
  frames, emits a 76-word parameter frame per segment and loops decoding.
  Assumes the tester paces samples; the speech algorithm is out of scope.
*/
`timescale 1ns/10ps
module chs_codec_end (
  input wire logic core_clk_i,
  input wire logic reset_i,
  chs_if.codec lnk,
  input wire logic frame_bad_i,
  output logic homed_o
);
  import chs_pkg::*;

  typedef enum {ST_IN, ST_OUT} chs_state_e;
  chs_state_e state_reg, state_next;
  logic [7:0] cnt_reg, cnt_next;
  logic all_home_reg, all_home_next;
  logic homed_reg, homed_next;
  logic emit_home_reg, emit_home_next;
  logic [15:0] sig_reg, sig_next;
  logic [15:0] hist_reg, hist_next;
  logic [6:0] ocnt_reg, ocnt_next;
  logic [15:0] pdata_reg, pdata_next;
  logic pval_reg, pval_next;
  logic pfirst_reg, pfirst_next;
  logic dhome_full_reg, dhome_full_next;
  logic dmatch_reg, dmatch_next;
  logic dall_reg, dall_next;
  logic [6:0] dcnt_reg, dcnt_next;
  logic dec_home_out_reg, dec_home_out_next;
  logic [15:0] ddata_reg, ddata_next;
  logic dval_reg, dval_next;
  logic [7:0] dout_reg, dout_next;
  logic [12:0] smp;

  // Only the top 13 bits count; the pad bits are ignored
  assign smp = lnk.smp_data[15:3];

  // Encoder: collect a segment, then emit its parameter frame
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    all_home_next = all_home_reg;
    homed_next = homed_reg;
    emit_home_next = emit_home_reg;
    sig_next = sig_reg;
    hist_next = hist_reg;
    ocnt_next = ocnt_reg;
    pdata_next = pdata_reg;
    pval_next = 1'b0;
    pfirst_next = 1'b0;
    unique case (state_reg)
      ST_IN: begin
        if (lnk.smp_valid) begin
          all_home_next = all_home_reg & (smp == HOME_SAMPLE);
          // Signature folds each sample with its position so offsets differ
          sig_next = {sig_reg[14:0], sig_reg[15]} ^ {3'h0, smp} ^ {8'h00, cnt_reg};
          if (cnt_reg == 8'(FRAME_SAMPLES - 1)) begin
            cnt_next = 8'h00;
            state_next = ST_OUT;
            ocnt_next = 7'h00;
            if (all_home_reg & (smp == HOME_SAMPLE)) begin
              emit_home_next = homed_reg;
              homed_next = 1'b1;
              hist_next = 16'h0000;
            end else begin
              emit_home_next = 1'b0;
              homed_next = 1'b0;
              hist_next = sig_next ^ hist_reg;
            end
          end else begin
            cnt_next = cnt_reg + 8'h01;
          end
        end
      end
      ST_OUT: begin
        pval_next = 1'b1;
        pfirst_next = (ocnt_reg == 7'h00);
        // Right-justified words; the homing response is a fixed frame.
        // Bit 5 marks a coded word, so no coded word can pass for the homing pattern.
        pdata_next = emit_home_reg ? DEC_HOME_WORD
                     : {10'h000, 1'b1, 5'(hist_reg >> ocnt_reg[3:0]) ^ 5'(ocnt_reg)};
        if (ocnt_reg == 7'(PARAM_WORDS - 1)) begin
          state_next = ST_IN;
          all_home_next = 1'b1;
          sig_next = 16'h0000;
        end else begin
          ocnt_next = ocnt_reg + 7'h01;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state_reg <= ST_IN;
      cnt_reg <= 8'h00;
      all_home_reg <= 1'b1;
      homed_reg <= 1'b0;
      emit_home_reg <= 1'b0;
      sig_reg <= 16'h0000;
      hist_reg <= 16'h0000;
      ocnt_reg <= 7'h00;
      pdata_reg <= 16'h0000;
      pval_reg <= 1'b0;
      pfirst_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      all_home_reg <= all_home_next;
      homed_reg <= homed_next;
      emit_home_reg <= emit_home_next;
      sig_reg <= sig_next;
      hist_reg <= hist_next;
      ocnt_reg <= ocnt_next;
      pdata_reg <= pdata_next;
      pval_reg <= pval_next;
      pfirst_reg <= pfirst_next;
    end
  end

  // Decoder: watch the parameter words looped back and track homing
  always_comb begin
    dhome_full_next = dhome_full_reg;
    dmatch_next = dmatch_reg;
    dall_next = dall_reg;
    dcnt_next = dcnt_reg;
    dec_home_out_next = dec_home_out_reg;
    if (pval_reg) begin
      if (pfirst_reg) begin
        dmatch_next = (pdata_reg == DEC_HOME_WORD);
        dall_next = (pdata_reg == DEC_HOME_WORD);
        dcnt_next = 7'h01;
      end else begin
        // Partial match only needs log_area_params and first subframe
        if (dcnt_reg < 7'(LOG_AREA_WORDS + SUB1_WORDS))
          dmatch_next = dmatch_reg & (pdata_reg == DEC_HOME_WORD);
        dall_next = dall_reg & (pdata_reg == DEC_HOME_WORD);
        dcnt_next = dcnt_reg + 7'h01;
      end
      if (dcnt_reg == 7'(PARAM_WORDS - 1)) begin
        dec_home_out_next = dhome_full_reg & dmatch_next;
        // Only a complete homing frame not flagged bad arms the partial-match reset
        dhome_full_next = dall_next & ~frame_bad_i;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      dhome_full_reg <= 1'b0;
      dmatch_reg <= 1'b0;
      dall_reg <= 1'b0;
      dcnt_reg <= 7'h00;
      dec_home_out_reg <= 1'b0;
    end else begin
      dhome_full_reg <= dhome_full_next;
      dmatch_reg <= dmatch_next;
      dall_reg <= dall_next;
      dcnt_reg <= dcnt_next;
      dec_home_out_reg <= dec_home_out_next;
    end
  end

  // Decoder output: one sample per input sample slot
  always_comb begin
    dout_next = dout_reg;
    dval_next = 1'b0;
    ddata_next = ddata_reg;
    if (lnk.smp_valid) begin
      dval_next = 1'b1;
      dout_next = (dout_reg == 8'(FRAME_SAMPLES - 1)) ? 8'h00 : dout_reg + 8'h01;
      ddata_next = dec_home_out_reg ? HOME_WORD
                   : {5'h00, dout_reg, PAD_ZERO};
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      dout_reg <= 8'h00;
      dval_reg <= 1'b0;
      ddata_reg <= 16'h0000;
    end else begin
      dout_reg <= dout_next;
      dval_reg <= dval_next;
      ddata_reg <= ddata_next;
    end
  end

  assign lnk.par_valid = pval_reg;
  assign lnk.par_data = pdata_reg;
  assign lnk.par_first = pfirst_reg;
  assign lnk.dec_valid = dval_reg;
  assign lnk.dec_data = ddata_reg;
  assign homed_o = homed_reg;
endmodule // chs_codec_end

/* shared/chs_pkg.sv */
/*
  Shared constants for the codec homing and alignment-search pair.
  Assumes one 200 MHz core clock shared by both ends.
*/
package chs_pkg;
  localparam int SAMPLE_BITS = 13;
  localparam int WORD_BITS = 16;
  localparam int FRAME_SAMPLES = 160;
  localparam int PARAM_WORDS = 76;
  localparam int LOG_AREA_WORDS = 8;
  localparam int SUB1_WORDS = 17;
  localparam int BIT_TRIALS = 13;
  localparam int TRIAL_FRAMES = 3;
  localparam int FRAME_MS = 20;
  localparam int SAMPLE_RATE_HZ = 8000;
  localparam int LINK_KBPS = 104;
  localparam int CLK_HZ = 200000000;
  // Clock cycles per sample slot at 104 kbit/s / 13 bits
  localparam int SAMPLE_CYCLES = CLK_HZ / ((LINK_KBPS * 1000) / SAMPLE_BITS);
  localparam logic [12:0] HOME_SAMPLE = 13'h0001;
  localparam logic [15:0] HOME_WORD = 16'h0008;
  localparam logic [15:0] DEC_HOME_WORD = 16'h0000;
  localparam logic [2:0] PAD_ZERO = 3'h0;
endpackage

/* shared/chs_if.sv */
/*
  Link between the codec end and the tester end.
  Assumes both ends share core_clk_i and reset_i.
*/
`timescale 1ns/10ps
interface chs_if;
  logic smp_valid;
  logic [15:0] smp_data;
  logic par_valid;
  logic [15:0] par_data;
  logic par_first;
  logic dec_valid;
  logic [15:0] dec_data;

  modport codec (input smp_valid, input smp_data, output par_valid, output par_data,
    output par_first, output dec_valid, output dec_data);
  modport tester (output smp_valid, output smp_data, input par_valid, input par_data,
    input par_first, input dec_valid, input dec_data);
endinterface

/* rtl/chs_tester_end.sv */
/*
  Tester end: bit-alignment search over 13 trials, then frame alignment with
  three homing frames and a sync frame; records the frame after the trigger.
  Assumes the codec end answers each segment with a 76-word frame.
*/
`timescale 1ns/10ps
module chs_tester_end #(
  parameter int PACE = chs_pkg::SAMPLE_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  chs_if.tester lnk,
  input wire logic start_i,
  input wire logic [15:0] sync_word_i,
  output logic [3:0] bit_shift_o,
  output logic bit_found_o,
  output logic fail_o,
  output logic rec_valid_o,
  output logic [15:0] rec_data_o,
  output logic done_o
);
  import chs_pkg::*;

  typedef enum {ST_IDLE, ST_BIT, ST_FRAME, ST_REC, ST_DONE, ST_FAIL} chs_tstate_e;
  chs_tstate_e st_reg, st_next;
  logic [3:0] shift_reg, shift_next;
  logic [2:0] fr_reg, fr_next;
  logic pv_reg, pv_next;
  logic frame_end;
  logic home_frame;
  logic [7:0] sc_reg, sc_next;
  logic [15:0] pace_reg, pace_next;
  logic match_reg, match_next;
  logic trig_reg, trig_next;
  logic sv_reg, sv_next;
  logic [15:0] sd_reg, sd_next;
  logic rv_reg, rv_next;
  logic [15:0] rd_reg, rd_next;
  logic tick;
  logic [15:0] home_shifted;

  // Homing word moved to the trial bit position, truncated to 13 bits
  assign home_shifted = {13'(HOME_SAMPLE << shift_reg), PAD_ZERO};
  assign tick = (pace_reg == 16'(PACE - 1));
  // A frame ends at the first idle cycle after a burst of encoded words
  assign frame_end = pv_reg & ~lnk.par_valid;
  // Judged only once the whole frame has been compared, never on a prefix
  assign home_frame = frame_end & match_reg;

  always_comb begin
    st_next = st_reg;
    shift_next = shift_reg;
    fr_next = fr_reg;
    sc_next = sc_reg;
    pace_next = tick ? 16'h0000 : pace_reg + 16'h0001;
    match_next = match_reg;
    pv_next = lnk.par_valid;
    trig_next = trig_reg;
    sv_next = 1'b0;
    sd_next = sd_reg;
    rv_next = 1'b0;
    rd_next = rd_reg;
    // Whole-frame compare against the stored all-zero decoder homing frame
    if (lnk.par_valid)
      match_next = (lnk.par_first | match_reg) & (lnk.par_data == DEC_HOME_WORD);
    // A new frame drops the trigger until it too proves to be a homing frame
    if (lnk.par_valid && lnk.par_first)
      trig_next = 1'b0;
    unique case (st_reg)
      ST_IDLE: if (start_i) begin
        st_next = ST_BIT;
        shift_next = 4'h0;
        fr_next = 3'h0;
        sc_next = 8'h00;
        trig_next = 1'b0;
      end
      ST_BIT, ST_FRAME: begin
        if (tick && fr_reg != 3'(TRIAL_FRAMES + 1)) begin
          sv_next = 1'b1;
          sd_next = (st_reg == ST_FRAME && fr_reg == 3'(TRIAL_FRAMES)) ? sync_word_i
                    : home_shifted;
          if (sc_reg == 8'(FRAME_SAMPLES - 1)) begin
            sc_next = 8'h00;
            fr_next = fr_reg + 3'h1;
          end else begin
            sc_next = sc_reg + 8'h01;
          end
        end
        if (st_reg == ST_BIT && home_frame) begin
          st_next = ST_FRAME;
          fr_next = 3'h0;
          sc_next = 8'h00;
        end else if (st_reg == ST_FRAME && home_frame) begin
          trig_next = 1'b1;
        end
        // The first non-homing frame after a homing frame is the one recorded
        if (st_reg == ST_FRAME && trig_reg && lnk.par_valid && lnk.par_first
            && lnk.par_data != DEC_HOME_WORD) begin
          st_next = ST_REC;
          rv_next = 1'b1;
          rd_next = lnk.par_data;
        end
        // Trial over without a homing frame: move one bit and retry
        if (st_reg == ST_BIT && fr_reg == 3'(TRIAL_FRAMES) && sc_reg == 8'h00
            && !lnk.par_valid && pace_reg == 16'h0000) begin
          if (shift_reg == 4'(BIT_TRIALS - 1))
            st_next = ST_FAIL;
          else begin
            shift_next = shift_reg + 4'h1;
            fr_next = 3'h0;
          end
        end
      end
      ST_REC: if (lnk.par_valid) begin
        rv_next = 1'b1;
        rd_next = lnk.par_data;
      end else begin
        st_next = ST_DONE; // Reference match and shift back are done by software
      end
      ST_DONE, ST_FAIL: if (start_i) st_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      st_reg <= ST_IDLE;
      shift_reg <= 4'h0;
      fr_reg <= 3'h0;
      pv_reg <= 1'b0;
      sc_reg <= 8'h00;
      pace_reg <= 16'h0000;
      match_reg <= 1'b0;
      trig_reg <= 1'b0;
      sv_reg <= 1'b0;
      sd_reg <= 16'h0000;
      rv_reg <= 1'b0;
      rd_reg <= 16'h0000;
    end else begin
      st_reg <= st_next;
      shift_reg <= shift_next;
      fr_reg <= fr_next;
      pv_reg <= pv_next;
      sc_reg <= sc_next;
      pace_reg <= pace_next;
      match_reg <= match_next;
      trig_reg <= trig_next;
      sv_reg <= sv_next;
      sd_reg <= sd_next;
      rv_reg <= rv_next;
      rd_reg <= rd_next;
    end
  end

  assign lnk.smp_valid = sv_reg;
  assign lnk.smp_data = sd_reg;
  assign bit_shift_o = shift_reg;
  assign bit_found_o = (st_reg != ST_BIT) && (st_reg != ST_IDLE) && (st_reg != ST_FAIL);
  assign fail_o = (st_reg == ST_FAIL);
  assign rec_valid_o = rv_reg;
  assign rec_data_o = rd_reg;
  assign done_o = (st_reg == ST_DONE);
endmodule // chs_tester_end

/* testbench/chs_link_properties.sv */
/* Checker for the link between the codec end and the tester end.
   Assumes it sits beside the link, fed with its signals, one clock. */
`timescale 1ns/10ps
module chs_link_properties
  import chs_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic smp_valid,
  input wire logic [15:0] smp_data,
  input wire logic par_valid,
  input wire logic [15:0] par_data,
  input wire logic par_first,
  input wire logic dec_valid,
  input wire logic [15:0] dec_data
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  logic [7:0] smp_cnt_reg;
  logic [6:0] burst_cnt_reg;
  logic seg_home_reg;
  logic prev_home_reg;
  logic last_smp;
  logic home_smp;
  assign last_smp = smp_valid && (smp_cnt_reg == 8'h9f);
  assign home_smp = (smp_data == HOME_WORD);
  // Segment position and homing history as the codec should count them
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      smp_cnt_reg <= 8'h00;
      burst_cnt_reg <= 7'h00;
      seg_home_reg <= 1'b1;
      prev_home_reg <= 1'b0;
    end else begin
      burst_cnt_reg <= par_valid ? burst_cnt_reg + 7'h01 : 7'h00;
      if (smp_valid) begin
        smp_cnt_reg <= last_smp ? 8'h00 : smp_cnt_reg + 8'h01;
        seg_home_reg <= last_smp ? 1'b1 : (seg_home_reg && home_smp);
        if (last_smp) begin
          prev_home_reg <= seg_home_reg && home_smp;
        end
      end
    end
  end

  property p_smp_zero; smp_valid |-> smp_data[2:0] == PAD_ZERO; endproperty
  a_smp_zero: assert property (p_smp_zero) else $error("sample low bits set");
  property p_smp_pace; smp_valid |=> !smp_valid [*8]; endproperty
  a_smp_pace: assert property (p_smp_pace) else $error("samples too close");
  property p_dec_follow; smp_valid |=> dec_valid; endproperty
  a_dec_follow: assert property (p_dec_follow) else $error("decoder sample missing");
  property p_dec_zero; dec_valid |-> dec_data[2:0] == PAD_ZERO; endproperty
  a_dec_zero: assert property (p_dec_zero) else $error("decoder low bits set");
  property p_answer; last_smp |-> ##2 (par_valid && par_first); endproperty
  a_answer: assert property (p_answer) else $error("frame not answered");
  property p_rose_cause; $rose(par_valid) |-> $past(last_smp, 2); endproperty
  a_rose_cause: assert property (p_rose_cause) else $error("burst without segment");
  property p_burst_len; $fell(par_valid) |-> burst_cnt_reg == 7'h4c; endproperty
  a_burst_len: assert property (p_burst_len) else $error("burst length wrong");
  property p_first_lead; par_first |-> par_valid && !$past(par_valid); endproperty
  a_first_lead: assert property (p_first_lead) else $error("first flag misplaced");
  // Only the log-area words are held to the pattern here; the bench checks all 76
  property p_home_answer;
    last_smp && prev_home_reg && seg_home_reg && home_smp
      |-> ##2 (par_valid && par_data == DEC_HOME_WORD) [*8];
  endproperty
  a_home_answer: assert property (p_home_answer) else $error("no homing answer");
endmodule // chs_link_properties

/* testbench/codec_homing_frame_sync_tb_top.sv */
/* Top bench: codec end and tester end joined by the link, with a model.
   Assumes the design pair, the link interface and the shared package. */
`timescale 1ns/10ps
module codec_homing_frame_sync_tb_top;
  import chs_pkg::*;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic frame_bad_i = 1'b0;
  logic start_i = 1'b0;
  logic [15:0] sync_word_i = 16'h0000;
  logic homed_o, bit_found_o, fail_o, rec_valid_o, done_o;
  logic [3:0] bit_shift_o;
  logic [15:0] rec_data_o;
  logic [31:0] lfsr = 32'h88b0d683;
  int failures = 0;
  int comparisons = 0;
  int nsmp = 0;
  int seg_cnt = 0;
  bit seg_home = 1'b1;
  bit hist[$];
  bit armed = 1'b0;
  bit found_seen = 1'b0;
  bit home;
  bit exp_home;
  bit full_m = 1'b0;
  bit dhome_m = 1'b0;
  bit dmatch;
  bit bad_last = 1'b0;
  logic [15:0] exp_dec;
  logic [3:0] found_shift;
  logic [15:0] frame_q[$];
  logic [15:0] exp_rec[$];
  logic [15:0] rec_q[$];
  chs_if lnk();
  chs_codec_end i_chs_codec_end (.core_clk_i(core_clk_i), .reset_i(reset_i), .lnk(lnk),
    .frame_bad_i(frame_bad_i), .homed_o(homed_o));
  // An 80-cycle pacing outlasts the 76-word answer and keeps the whole search under the cycle budget
  chs_tester_end #(.PACE(80)) i_chs_tester_end (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .lnk(lnk), .start_i(start_i), .sync_word_i(sync_word_i), .bit_shift_o(bit_shift_o),
    .bit_found_o(bit_found_o), .fail_o(fail_o), .rec_valid_o(rec_valid_o),
    .rec_data_o(rec_data_o), .done_o(done_o));
  chs_link_properties i_chs_link_properties (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .smp_valid(lnk.smp_valid), .smp_data(lnk.smp_data), .par_valid(lnk.par_valid),
    .par_data(lnk.par_data), .par_first(lnk.par_first), .dec_valid(lnk.dec_valid),
    .dec_data(lnk.dec_data));

  always #2.5 core_clk_i = ~core_clk_i;

  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("counts: %0d comparisons, %0d failures", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Random sync samples keep the low pad bits clear, as the link checker expects
  always @(negedge core_clk_i) begin
    lfsr <= lfsr_step(lfsr);
    frame_bad_i <= lfsr[0];
    sync_word_i <= {lfsr[15:3], 3'h0};
  end

  // Model: segments the sample stream and predicts each encoded frame
  always @(negedge core_clk_i) begin
    if (!reset_i && lnk.smp_valid) begin
      nsmp++;
      seg_home &= (lnk.smp_data === HOME_WORD);
      seg_cnt++;
      if (seg_cnt == FRAME_SAMPLES) begin
        hist.push_back(seg_home);
        seg_home = 1'b1;
        seg_cnt = 0;
      end
    end
    if (!reset_i && lnk.par_valid) begin
      if (frame_q.size() == 0) check("first flag", 16'h0001, {15'h0, lnk.par_first});
      // The codec reads the bad flag with the last word: the value being driven now
      if (frame_q.size() == PARAM_WORDS - 1) bad_last = lfsr[0];
      frame_q.push_back(lnk.par_data);
    end
    if (!reset_i && lnk.dec_valid) begin
      exp_dec = dhome_m ? HOME_WORD : {5'h00, 8'((nsmp - 1) % FRAME_SAMPLES), 3'h0};
      check("decoder sample", exp_dec, lnk.dec_data);
    end
    if (frame_q.size() == PARAM_WORDS && !lnk.par_valid) begin
      home = 1'b1;
      foreach (frame_q[i]) home &= (frame_q[i] === DEC_HOME_WORD);
      exp_home = (hist.size() >= 2) && hist[$] && hist[$-1];
      check("homing frame", 16'(exp_home), 16'(home));
      if (hist.size() > 0) check("homed", 16'(hist[$]), {15'h0, homed_o});
      // Decoder side: a complete good homing frame arms, a partial match then resets
      dmatch = 1'b1;
      for (int i = 0; i < LOG_AREA_WORDS + SUB1_WORDS; i++) dmatch &= (frame_q[i] === 16'h0);
      dhome_m = full_m && dmatch;
      full_m = home && !bad_last;
      if (home) begin
        armed = 1'b1;
      end else if (armed) begin
        exp_rec = frame_q;
        armed = 1'b0;
      end
      frame_q = {};
    end
    if (rec_valid_o) rec_q.push_back(rec_data_o);
    if (bit_found_o === 1'b1 && !found_seen) begin
      found_seen = 1'b1;
      found_shift = bit_shift_o;
      check("bit shift", 16'(nsmp / (TRIAL_FRAMES * FRAME_SAMPLES)), {12'h0, bit_shift_o});
    end
  end

  initial begin
    repeat (10) @(posedge core_clk_i);
    @(negedge core_clk_i);
    reset_i = 1'b0;
    @(negedge core_clk_i);
    check("idle outputs", 16'h0, {12'h0, done_o, fail_o, bit_found_o, lnk.par_valid});
    $display("test reset finished");
    start_i = 1'b1;
    @(negedge core_clk_i);
    start_i = 1'b0;
    for (int n = 0; n < 90000 && done_o !== 1'b1 && fail_o !== 1'b1; n++) begin
      @(negedge core_clk_i);
    end
    if (done_o !== 1'b1 && fail_o !== 1'b1) begin
      failures++;
      $display("unexpected search end: expected done seen none");
      print_verdict();
    end
    check("search failed", 16'h0, {15'h0, fail_o});
    check("kept shift", {12'h0, found_shift}, {12'h0, bit_shift_o});
    check("sync frame", 16'h0, 16'(hist[$]));
    check("two homing before", 16'h3, {14'h0, hist[$-1], hist[$-2]});
    check("recorded count", 16'(PARAM_WORDS), 16'(rec_q.size()));
    check("reference count", 16'(PARAM_WORDS), 16'(exp_rec.size()));
    if (rec_q.size() == exp_rec.size()) begin
      foreach (rec_q[i]) check("recorded word", exp_rec[i], rec_q[i]);
    end
    $display("test search finished");
    print_verdict();
  end
endmodule // codec_homing_frame_sync_tb_top
